// file: logic/aaf_filter.sv
// Accumulate/average/low-pass filter stage behind a conversion result, APB registers.
// Assumes result_valid pulses once per finished conversion; conv_tick pulses per converter clock.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "aaf_params.svh"
module aaf_filter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic result_valid,
	input wire logic [15:0] result_data,
	input wire logic conv_tick,
	output logic threshold_interrupt_flag,
	output logic [15:0] filter_result
);
	logic [2:0] mode_ff, nxt_mode;
	logic [2:0] shift_ff, nxt_shift;
	logic accum_clear_cmd_ff, nxt_accum_clear_cmd;
	logic [7:0] repeat_setting_ff, nxt_repeat_setting;
	logic [7:0] sample_count_ff, nxt_sample_count;
	logic [17:0] acc_ff, nxt_acc;
	logic [15:0] flt_ff, nxt_flt;
	logic [15:0] thr_ff, nxt_thr;
	logic accum_overflow_flag_ff, nxt_accum_overflow_flag;
	logic thr_flag_ff, nxt_thr_flag;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic clr_start, clr_busy, clr_done;

	logic sel_ctrl, sel_rpt, sel_cnt, sel_accl, sel_acch, sel_accu, sel_flt, sel_stat, sel_thr, sel_none;
	logic [15:0] cmp_val;
	logic cmp_en;

	// Shifted view, also used by low-pass feedback
	function automatic logic [17:0] shr(input logic [17:0] v, input logic [2:0] s);
		shr = v >> s;
	endfunction

	// Clamp into the 16-bit result; anything above reads as full scale
	function automatic logic [15:0] sat16(input logic [17:0] v);
		sat16 = (v[17:16] != 2'h0) ? 16'hFFFF : v[15:0];
	endfunction

	// Count stops at its top rather than wrapping back to zero
	function automatic logic [7:0] inc_sat8(input logic [7:0] v);
		inc_sat8 = (v != 8'hFF) ? v + 8'h01 : v;
	endfunction

	function automatic logic over_thr(input logic [15:0] v, input logic [15:0] t);
		over_thr = (v > t);
	endfunction

	function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] ofs);
		is_ofs = (a == ofs);
	endfunction

	wire logic setup = psel && !penable;
	wire logic wr_access = psel && penable && pwrite && pready_ff;
	wire logic [18:0] acc_sum = {1'b0, acc_ff} + {3'h0, result_data};

	aaf_clear_seq u_clr (
		.pclk(pclk),
		.presetn(presetn),
		.start(clr_start),
		.conv_tick(conv_tick),
		.busy(clr_busy),
		.done(clr_done)
	);

	// One-hot register select; anything off the map answers with an error
	always_comb begin
		sel_ctrl = 1'b0;
		sel_rpt = 1'b0;
		sel_cnt = 1'b0;
		sel_accl = 1'b0;
		sel_acch = 1'b0;
		sel_accu = 1'b0;
		sel_flt = 1'b0;
		sel_stat = 1'b0;
		sel_thr = 1'b0;
		sel_none = 1'b0;
		if (is_ofs(paddr, `AAF_OFS_CTRL)) begin
			sel_ctrl = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_RPT)) begin
			sel_rpt = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_CNT)) begin
			sel_cnt = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_ACCL)) begin
			sel_accl = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_ACCH)) begin
			sel_acch = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_ACCU)) begin
			sel_accu = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_FLT)) begin
			sel_flt = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_STAT)) begin
			sel_stat = 1'b1;
		end else if (is_ofs(paddr, `AAF_OFS_THR)) begin
			sel_thr = 1'b1;
		end else begin
			sel_none = 1'b1;
		end
	end

	// Bus: answer registered in the setup cycle, so every access has one cycle
	// Read data stays zero on writes so a stale value never looks valid
	always_comb begin
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		nxt_prdata = 32'h0000_0000;
		if (setup) begin
			nxt_pready = 1'b1;
			nxt_pslverr = sel_none;
			if (!pwrite) begin
				if (sel_ctrl) begin
					nxt_prdata[`AAF_CTRL_MODE_LSB +: 3] = mode_ff;
					nxt_prdata[`AAF_CTRL_SHIFT_LSB +: 3] = shift_ff;
					nxt_prdata[`AAF_CTRL_CLR_BIT] = accum_clear_cmd_ff;
				end else if (sel_rpt) begin
					nxt_prdata[7:0] = repeat_setting_ff;
				end else if (sel_cnt) begin
					nxt_prdata[7:0] = sample_count_ff;
				end else if (sel_accl) begin
					nxt_prdata[7:0] = acc_ff[7:0];
				end else if (sel_acch) begin
					nxt_prdata[7:0] = acc_ff[15:8];
				end else if (sel_accu) begin
					nxt_prdata[1:0] = acc_ff[17:16];
				end else if (sel_flt) begin
					nxt_prdata[15:0] = flt_ff;
				end else if (sel_stat) begin
					nxt_prdata[`AAF_STAT_OVF_BIT] = accum_overflow_flag_ff;
					nxt_prdata[`AAF_STAT_THR_BIT] = thr_flag_ff;
				end else if (sel_thr) begin
					nxt_prdata[15:0] = thr_ff;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// A second clear request while one runs is ignored
	assign clr_start = wr_access && sel_ctrl && pwdata[`AAF_CTRL_CLR_BIT] && !accum_clear_cmd_ff;

	// Control registers; the clear bit is dropped only by the sequencer
	always_comb begin
		nxt_mode = mode_ff;
		nxt_shift = shift_ff;
		nxt_repeat_setting = repeat_setting_ff;
		nxt_thr = thr_ff;
		nxt_accum_clear_cmd = accum_clear_cmd_ff;
		if (wr_access) begin
			if (sel_ctrl) begin
				nxt_mode = pwdata[`AAF_CTRL_MODE_LSB +: 3];
				nxt_shift = pwdata[`AAF_CTRL_SHIFT_LSB +: 3];
			end else if (sel_rpt) begin
				nxt_repeat_setting = pwdata[7:0];
			end else if (sel_thr) begin
				nxt_thr = pwdata[15:0];
			end
		end
		if (clr_start) begin
			nxt_accum_clear_cmd = 1'b1;
		end
		if (clr_done) begin
			nxt_accum_clear_cmd = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= 3'h0;
			shift_ff <= 3'h0;
			repeat_setting_ff <= `AAF_RPT_RESET;
			thr_ff <= `AAF_THR_RESET;
			accum_clear_cmd_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			shift_ff <= nxt_shift;
			repeat_setting_ff <= nxt_repeat_setting;
			thr_ff <= nxt_thr;
			accum_clear_cmd_ff <= nxt_accum_clear_cmd;
		end
	end

	// What the threshold compare looks at in basic, accumulate and average modes; off in the others
	always_comb begin
		cmp_val = 16'h0000;
		cmp_en = 1'b0;
		case (aaf_pkg::aaf_mode_t'(mode_ff))
			aaf_pkg::AAF_MODE_BASIC: begin
				cmp_val = result_data;
				cmp_en = 1'b1;
			end
			aaf_pkg::AAF_MODE_ACCUM: begin
				cmp_val = sat16(acc_sum[17:0]);
				cmp_en = 1'b1;
			end
			aaf_pkg::AAF_MODE_AVG: begin
				cmp_val = sat16(shr(acc_sum[17:0], shift_ff));
				cmp_en = (inc_sat8(sample_count_ff) >= repeat_setting_ff);
			end
			default: begin
				cmp_en = 1'b0;
			end
		endcase
	end

	// Datapath: accumulator, count, filter result and status flags
	always_comb begin
		nxt_sample_count = sample_count_ff;
		nxt_acc = acc_ff;
		nxt_flt = flt_ff;
		nxt_accum_overflow_flag = accum_overflow_flag_ff;
		nxt_thr_flag = thr_flag_ff;
		// Write one clears the threshold flag; a set in the same cycle wins below
		if (wr_access && sel_stat && pwdata[`AAF_STAT_THR_BIT]) begin
			nxt_thr_flag = 1'b0;
		end
		if (clr_busy) begin
			// Samples arriving during a clear are dropped; clear wins
			nxt_acc = 18'h0_0000;
			nxt_sample_count = 8'h00;
			nxt_accum_overflow_flag = 1'b0;
		end else if (result_valid) begin
			case (aaf_pkg::aaf_mode_t'(mode_ff))
				aaf_pkg::AAF_MODE_BASIC: begin
					// No accumulation; raw result compared
					nxt_flt = result_data;
				end
				aaf_pkg::AAF_MODE_ACCUM, aaf_pkg::AAF_MODE_AVG: begin
					nxt_acc = acc_sum[17:0];
					if (acc_sum > {1'b0, `AAF_ACC_MAX}) begin
						nxt_accum_overflow_flag = 1'b1;
					end
					nxt_sample_count = inc_sat8(sample_count_ff);
					nxt_flt = sat16(shr(acc_sum[17:0], shift_ff));
				end
				aaf_pkg::AAF_MODE_LPF: begin
					// Cut-off set by shift, 0 gives widest band
					nxt_acc = acc_ff - shr(acc_ff, shift_ff) + {2'h0, result_data};
					nxt_sample_count = inc_sat8(sample_count_ff);
					nxt_flt = sat16(shr(acc_ff, shift_ff));
				end
				default: begin
					nxt_flt = flt_ff;
				end
			endcase
			if (cmp_en && over_thr(cmp_val, thr_ff)) begin
				nxt_thr_flag = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_count_ff <= 8'h00;
			acc_ff <= 18'h0_0000;
			flt_ff <= 16'h0000;
			accum_overflow_flag_ff <= 1'b0;
			thr_flag_ff <= 1'b0;
		end else begin
			sample_count_ff <= nxt_sample_count;
			acc_ff <= nxt_acc;
			flt_ff <= nxt_flt;
			accum_overflow_flag_ff <= nxt_accum_overflow_flag;
			thr_flag_ff <= nxt_thr_flag;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign threshold_interrupt_flag = thr_flag_ff;
	assign filter_result = flt_ff;
endmodule
`default_nettype wire

// file: logic/aaf_params.svh
// Constants of the accumulate/average filter: register offsets, reset values, timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef AAF_PARAMS_SVH
`define AAF_PARAMS_SVH

`define AAF_OFS_CTRL 12'h000
`define AAF_OFS_RPT 12'h004
`define AAF_OFS_CNT 12'h008
`define AAF_OFS_ACCL 12'h00C
`define AAF_OFS_ACCH 12'h010
`define AAF_OFS_ACCU 12'h014
`define AAF_OFS_FLT 12'h018
`define AAF_OFS_STAT 12'h01C
`define AAF_OFS_THR 12'h020

`define AAF_CTRL_MODE_LSB 0
`define AAF_CTRL_SHIFT_LSB 4
`define AAF_CTRL_CLR_BIT 8
`define AAF_STAT_OVF_BIT 0
`define AAF_STAT_THR_BIT 1

`define AAF_ACC_MAX 18'h3FFFF
`define AAF_RPT_RESET 8'h00
`define AAF_THR_RESET 16'hFFFF
`define AAF_CLR_CYCLES 3'h5

`endif

// file: logic/aaf_pkg.sv
// Types of the accumulate/average filter.
// Assumes aaf_params.svh is on the include path.
`include "aaf_params.svh"
package aaf_pkg;
	typedef enum logic [2:0] {
		AAF_MODE_BASIC = 3'h0,
		AAF_MODE_ACCUM = 3'h1,
		AAF_MODE_AVG = 3'h2,
		AAF_MODE_BURST = 3'h3,
		AAF_MODE_LPF = 3'h4
	} aaf_mode_t;
	typedef enum logic [1:0] {
		AAF_CLR_IDLE,
		AAF_CLR_BUSY,
		AAF_CLR_DONE
	} aaf_clr_state_t;
endpackage

// file: logic/aaf_clear_seq.sv
// Clear sequencer: holds the accumulator clear for a fixed number of converter clocks.
// Assumes start is a one-cycle pulse and conv_tick marks converter clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "aaf_params.svh"
module aaf_clear_seq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic conv_tick,
	output logic busy,
	output logic done
);
	aaf_pkg::aaf_clr_state_t state_ff, nxt_state;
	logic [2:0] cnt_ff, nxt_cnt;
	logic done_ff, nxt_done;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		case (state_ff)
			aaf_pkg::AAF_CLR_IDLE: begin
				if (start) begin
					nxt_state = aaf_pkg::AAF_CLR_BUSY;
					nxt_cnt = 3'h0;
				end
			end
			aaf_pkg::AAF_CLR_BUSY: begin
				if (conv_tick) begin
					if (cnt_ff == `AAF_CLR_CYCLES - 3'h1) begin
						nxt_state = aaf_pkg::AAF_CLR_DONE;
					end else begin
						nxt_cnt = cnt_ff + 3'h1;
					end
				end
			end
			aaf_pkg::AAF_CLR_DONE: begin
				nxt_done = 1'b1;
				nxt_state = aaf_pkg::AAF_CLR_IDLE;
			end
			default: nxt_state = aaf_pkg::AAF_CLR_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= aaf_pkg::AAF_CLR_IDLE;
			cnt_ff <= 3'h0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign busy = (state_ff != aaf_pkg::AAF_CLR_IDLE);
	assign done = done_ff;
endmodule
`default_nettype wire

// file: verif/aaf_filter_properties.sv
// Checker on the filter ports: bus answer timing and sample-driven outputs.
// Assumes it is bound to aaf_filter and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "aaf_params.svh"
module aaf_filter_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic result_valid,
	input wire logic threshold_interrupt_flag,
	input wire logic [15:0] filter_result
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_rdy1; pready |=> !pready; endproperty
	a_rdy1: assert property (p_rdy1) else $error("ready held");
	property p_rd0; !pready || pwrite |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("stray read data");
	property p_err; pready |-> pslverr == (paddr > `AAF_OFS_THR); endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_erq; pslverr |-> pready; endproperty
	a_erq: assert property (p_erq) else $error("error without ready");
	property p_accu; pready && !pwrite && paddr == `AAF_OFS_ACCU |-> prdata[31:2] == 30'h0; endproperty
	a_accu: assert property (p_accu) else $error("upper bits wide");
	property p_flt; $changed(filter_result) |-> $past(result_valid); endproperty
	a_flt: assert property (p_flt) else $error("result moved alone");
	property p_thr; $rose(threshold_interrupt_flag) |-> $past(result_valid); endproperty
	a_thr: assert property (p_thr) else $error("flag rose alone");
endmodule
bind aaf_filter aaf_filter_properties aaf_filter_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .result_valid, .threshold_interrupt_flag, .filter_result);
`default_nettype wire

// file: verif/aaf_conv_model.sv
// Converter core model: one result pulse per request, tick at full or quarter rate.
// Assumes the bench raises req for one cycle per conversion.
`timescale 1ns/1ps
`default_nettype none
module aaf_conv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic [15:0] req_data,
	input wire logic slow,
	output logic result_valid,
	output logic [15:0] result_data,
	output logic conv_tick
);
	logic [1:0] ph_ff;
	// Idle data inverts each cycle so a stale sample shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) {ph_ff, result_valid, result_data} <= 19'h0;
		else {ph_ff, result_valid, result_data} <= {ph_ff + 2'h1, req, req ? req_data : ~result_data};
	end
	assign conv_tick = !slow || ph_ff == 2'h3;
endmodule
`default_nettype wire

// file: verif/test_aaf_filter.sv
// Bench for the filter: APB tasks, converter model, one task per scenario.
// Assumes design, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "aaf_params.svh"
module test_aaf_filter;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req = 1'b0, slow = 1'b0;
	logic pready, pslverr, rv, tick, tif, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [15:0] rdat, flt, req_data = 16'h0000;
	int fail_count = 0, n_compared = 0;
	always #2 pclk = ~pclk;
	aaf_filter aaf_filter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .result_valid(rv), .result_data(rdat), .conv_tick(tick),
		.threshold_interrupt_flag(tif), .filter_result(flt));
	aaf_conv_model aaf_conv_model_inst (.pclk, .presetn, .req, .req_data, .slow,
		.result_valid(rv), .result_data(rdat), .conv_tick(tick));
	task chk(string nm, logic [31:0] s, logic [31:0] x);
		n_compared++;
		if (s !== x) $display("MISMATCH %s exp %h seen %h", nm, x, s);
		fail_count += int'(s !== x);
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		// Ready and data are taken at the rising edge where the slave completes
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fail_count++;
		{q, e} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	task rc(string nm, logic [11:0] a, logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, q, x);
	endtask
	task smp(logic [15:0] d);
		@(posedge pclk) {req, req_data} <= {1'b1, d};
		@(posedge pclk) req <= 1'b0;
		@(posedge pclk);
		@(negedge pclk);
	endtask
	task poll;
		for (int n = 0; n < 30; n++) begin
			apb(1'b0, `AAF_OFS_CTRL, 32'h0);
			if (q[8] === 1'b0) break;
		end
		chk("clr_done", 32'(q[8]), 32'h0);
	endtask
	task t_reset;
		rc("rpt", `AAF_OFS_RPT, 32'h0);
		rc("thr", `AAF_OFS_THR, 32'hFFFF);
		apb(1'b0, 12'h024, 32'h0);
		chk("bad_err", 32'(e), 32'h1);
		chk("bad_data", q, 32'h0);
	endtask
	task t_accum;
		apb(1'b1, `AAF_OFS_CTRL, 32'h11);
		apb(1'b1, `AAF_OFS_RPT, 32'h2);
		smp(16'h0064);
		smp(16'h00C8);
		rc("accl", `AAF_OFS_ACCL, 32'h2C);
		rc("acch", `AAF_OFS_ACCH, 32'h1);
		rc("cnt", `AAF_OFS_CNT, 32'h2);
		chk("flt_acc", 32'(flt), 32'h96);
	endtask
	task t_clear;
		slow <= 1'b1;
		apb(1'b1, `AAF_OFS_CTRL, 32'h111);
		smp(16'h0007);
		rc("acc_clr", `AAF_OFS_ACCL, 32'h0);
		rc("busy", `AAF_OFS_CTRL, 32'h111);
		poll;
		slow <= 1'b0;
		rc("cnt_clr", `AAF_OFS_CNT, 32'h0);
	endtask
	task t_avg;
		apb(1'b1, `AAF_OFS_CTRL, 32'h22);
		apb(1'b1, `AAF_OFS_RPT, 32'h4);
		apb(1'b1, `AAF_OFS_THR, 32'h32);
		repeat (3) smp(16'h0064);
		chk("tif_early", 32'(tif), 32'h0);
		smp(16'h0064);
		chk("tif_avg", 32'(tif), 32'h1);
		chk("flt_avg", 32'(flt), 32'h64);
		apb(1'b1, `AAF_OFS_STAT, 32'h2);
		@(negedge pclk);
		chk("tif_w1c", 32'(tif), 32'h0);
	endtask
	task t_ovf;
		apb(1'b1, `AAF_OFS_CTRL, 32'h101);
		poll;
		apb(1'b1, `AAF_OFS_THR, 32'hFFFF);
		repeat (4) smp(16'hFFFF);
		smp(16'h0003);
		rc("ovf_edge", `AAF_OFS_STAT, 32'h0);
		rc("accu", `AAF_OFS_ACCU, 32'h3);
		smp(16'h0001);
		smp(16'h0005);
		rc("ovf_set", `AAF_OFS_STAT, 32'h1);
	endtask
	task t_lpf;
		apb(1'b1, `AAF_OFS_CTRL, 32'h114);
		poll;
		rc("ovf_clr", `AAF_OFS_STAT, 32'h0);
		smp(16'h0064);
		smp(16'h0064);
		rc("acc_lpf", `AAF_OFS_ACCL, 32'h96);
		chk("flt_lpf", 32'(flt), 32'h32);
		apb(1'b1, `AAF_OFS_CTRL, 32'h0);
		apb(1'b1, `AAF_OFS_THR, 32'h1000);
		smp(16'h2000);
		chk("tif_basic", 32'(tif), 32'h1);
		rc("acc_basic", `AAF_OFS_ACCL, 32'h96);
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_accum;
		t_clear;
		t_avg;
		t_ovf;
		t_lpf;
		tally_and_finish;
	end
	initial begin
		#20000;
		fail_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
